/* core/priv_xfer_pkg.sv */
// Shared constants and carriers for the privilege transfer unit
package priv_xfer_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_ENTRY_CS = 8'h0c;
    localparam logic [7:0] OFF_ENTRY_TGT_LO = 8'h10;
    localparam logic [7:0] OFF_ENTRY_TGT_HI = 8'h14;
    localparam logic [7:0] OFF_ENTRY_STK_LO = 8'h18;
    localparam logic [7:0] OFF_ENTRY_STK_HI = 8'h1c;
    localparam logic [7:0] OFF_OPA_LO = 8'h20;
    localparam logic [7:0] OFF_OPA_HI = 8'h24;
    localparam logic [7:0] OFF_OPB_LO = 8'h28;
    localparam logic [7:0] OFF_OPB_HI = 8'h2c;
    localparam logic [7:0] OFF_OPC = 8'h30;
    localparam logic [7:0] OFF_TSS_SP_LO = 8'h34;
    localparam logic [7:0] OFF_TSS_SP_HI = 8'h38;
    localparam logic [7:0] OFF_DSEG = 8'h3c;
    localparam logic [7:0] OFF_CUR = 8'h40;
    localparam logic [7:0] OFF_SP_LO = 8'h44;
    localparam logic [7:0] OFF_SP_HI = 8'h48;
    localparam logic [7:0] OFF_IP_LO = 8'h4c;
    localparam logic [7:0] OFF_IP_HI = 8'h50;
    localparam logic [7:0] OFF_SEGS = 8'h54;
    localparam logic [7:0] OFF_DATA_SEL = 8'h58;
    localparam logic [7:0] OFF_FRAME0 = 8'h60;
    localparam int FRAME_WORDS = 8;
    // Control fields
    localparam int CTRL_LONG = 0;
    localparam int CTRL_M64 = 1;
    // Command codes
    localparam logic [2:0] CMD_FAR_CALL = 3'h1;
    localparam logic [2:0] CMD_FAR_RET = 3'h2;
    localparam logic [2:0] CMD_NEAR_RET = 3'h3;
    localparam logic [2:0] CMD_INT_RET = 3'h4;
    localparam logic [2:0] CMD_ENTRY = 3'h5;
    localparam logic [2:0] CMD_EXIT = 3'h6;
    localparam logic [2:0] CMD_EXIT_W = 3'h7;
    // Fixed selector offsets and frame layout
    localparam logic [15:0] ENTRY_SS_ADD = 16'h0008;
    localparam logic [15:0] EXIT_CS_ADD = 16'h0010;
    localparam logic [15:0] EXIT_SS_ADD = 16'h0018;
    localparam logic [15:0] EXITW_CS_ADD = 16'h0020;
    localparam logic [15:0] EXITW_SS_ADD = 16'h0028;
    localparam logic [63:0] SLOT_BYTES = 64'h8;
    localparam logic [31:0] FLAT_LIMIT = 32'h0fffffff;
    localparam logic [1:0] LEVEL_TOP = 2'h0;
    localparam logic [1:0] LEVEL_USER = 2'h3;
    localparam logic [15:0] NULL_SEL = 16'h0000;
    // Fault codes
    localparam logic [1:0] FLT_NONE = 2'h0;
    localparam logic [1:0] FLT_GP = 2'h1;
    localparam logic [1:0] FLT_LIMIT = 2'h2;

    typedef struct packed {
        logic [15:0] sel;
        logic [1:0] descriptor_priv_level;
        logic conforming;
        logic isData;
        logic [31:0] limit;
    } seg_type;

    typedef struct packed {
        logic [15:0] codeSel;
        logic [15:0] stackSel;
        logic [63:0] ip;
        logic [63:0] sp;
        logic longCode;
        logic [31:0] csLimit;
        logic [31:0] ssLimit;
    } target_type;

    function automatic logic [1:0] rplOf(input logic [15:0] sel);
        return sel[1:0];
    endfunction
endpackage

/* core/data_seg_scrub.sv */
// Scrubs one data segment register after an outward return
`timescale 1ns/1ps
module data_seg_scrub
(
    input wire logic [15:0] selIn,
    input wire logic [1:0] segDpl,
    input wire logic segConforming,
    input wire logic [1:0] newLevel,
    output logic [15:0] selOut
);
    // Conforming code stays reachable at any level
    always_comb
    begin
        if (segDpl < newLevel && !segConforming)
            selOut = priv_xfer_pkg::NULL_SEL;
        else
            selOut = selIn;
    end
endmodule // data_seg_scrub

/* core/fast_xfer_gen.sv */
// Builds fast entry and exit target state
`timescale 1ns/1ps
module fast_xfer_gen
(
    input wire logic [2:0] cmd,
    input wire logic longActive,
    input wire logic [15:0] entryCodeSel,
    input wire logic [63:0] entryTarget,
    input wire logic [63:0] entryStack,
    input wire logic [63:0] dReg,
    input wire logic [63:0] cReg,
    output priv_xfer_pkg::target_type tgt
);
    always_comb
    begin
        tgt = '0;
        tgt.csLimit = priv_xfer_pkg::FLAT_LIMIT;
        tgt.ssLimit = priv_xfer_pkg::FLAT_LIMIT;
        case (cmd)
            priv_xfer_pkg::CMD_ENTRY:
            begin
                tgt.codeSel = entryCodeSel;
                tgt.stackSel = entryCodeSel + priv_xfer_pkg::ENTRY_SS_ADD;
                // Upper halves ignored outside the wide mode
                tgt.ip = longActive ? entryTarget : {32'h0, entryTarget[31:0]};
                tgt.sp = longActive ? entryStack : {32'h0, entryStack[31:0]};
                tgt.longCode = longActive;
            end
            priv_xfer_pkg::CMD_EXIT_W:
            begin
                tgt.codeSel = entryCodeSel + priv_xfer_pkg::EXITW_CS_ADD;
                tgt.stackSel = entryCodeSel + priv_xfer_pkg::EXITW_SS_ADD;
                tgt.ip = dReg;
                tgt.sp = cReg;
                tgt.longCode = 1'b1;
            end
            default:
            begin
                tgt.codeSel = entryCodeSel + priv_xfer_pkg::EXIT_CS_ADD;
                tgt.stackSel = entryCodeSel + priv_xfer_pkg::EXIT_SS_ADD;
                tgt.ip = {32'h0, dReg[31:0]};
                tgt.sp = {32'h0, cReg[31:0]};
                tgt.longCode = 1'b0;
            end
        endcase
    end
endmodule // fast_xfer_gen

/* core/privilege_transfer_unit.sv */
// Privilege transfer engine with an AXI4-Lite register port
`timescale 1ns/1ps
module privilege_transfer_unit
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0]
    {
        IDLE_ST = 3'b001,
        EXEC_ST = 3'b010,
        DONE_ST = 3'b100
    } state_type;

    localparam int FRAME_WORDS4 = priv_xfer_pkg::FRAME_WORDS;
    // Software visible state
    logic [1:0] ctrl_q, ctrl_d;
    logic [15:0] entryCs_q, entryCs_d;
    logic [63:0] entryTgt_q, entryTgt_d, entryStk_q, entryStk_d;
    logic [63:0] opA_q, opA_d, opB_q, opB_d, tssSp_q, tssSp_d;
    logic [31:0] opC_q, opC_d;
    logic [31:0] dseg_q, dseg_d;
    logic [1:0] cpl_q, cpl_d;
    logic [63:0] sp_q, sp_d, ip_q, ip_d;
    logic [15:0] cs_q, cs_d, ss_q, ss_d;
    logic [31:0] csLim_q, csLim_d, ssLim_q, ssLim_d;
    logic longCode_q, longCode_d, ssLoaded_q, ssLoaded_d;
    logic [15:0] dsel_q [4], dsel_d [4];
    logic [63:0] frame_q [FRAME_WORDS4], frame_d [FRAME_WORDS4];
    logic [1:0] fault_q, fault_d;
    logic [2:0] cmd_q, cmd_d;
    state_type state_q, state_d;
    // Bus handshake state
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d;
    logic [7:0] awAddr_q, awAddr_d, arAddr_q, arAddr_d;
    logic [31:0] wData_q, wData_d, rData_q, rData_d;
    logic rValid_q, rValid_d, bErr_q, bErr_d, rErr_q, rErr_d;

    priv_xfer_pkg::target_type fastTgt;
    logic [15:0] scrubbed [4];
    logic [1:0] newLevel;

    fast_xfer_gen u_fast
    (
        .cmd(cmd_q),
        .longActive(ctrl_q[priv_xfer_pkg::CTRL_LONG]),
        .entryCodeSel(entryCs_q),
        .entryTarget(entryTgt_q),
        .entryStack(entryStk_q),
        .dReg(opA_q),
        .cReg(opB_q),
        .tgt(fastTgt)
    );

    // Data segment descriptors packed 8 bits each: dpl[1:0], conforming
    assign newLevel = priv_xfer_pkg::rplOf(frame_q[1][15:0]);
    for (genvar g = 0; g < 4; g++)
    begin : g_scrub
        data_seg_scrub u_scrub
        (
            .selIn(dsel_q[g]),
            .segDpl(dseg_q[8*g +: 2]),
            .segConforming(dseg_q[8*g+2]),
            .newLevel(newLevel),
            .selOut(scrubbed[g])
        );
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[8*i +: 8] = val[8*i +: 8];
        return r;
    endfunction

    // Frame window starts off an eight-word boundary, so rebase first
    function automatic logic [2:0] slotOf(input logic [7:0] a);
        return 3'((a - priv_xfer_pkg::OFF_FRAME0) >> 3);
    endfunction

    logic wrFire, rdFire;
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign wrFire = awHeld_q && wHeld_q && !bValid_q;
    assign rdFire = s_axi_arvalid && !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bErr_q ? 2'h2 : 2'h0;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rErr_q ? 2'h2 : 2'h0;

    always_comb
    begin
        logic [31:0] rd;
        logic hit;
        logic [63:0] spx;
        rd = 32'h0;
        hit = 1'b1;
        spx = 64'h0;
        {ctrl_d, entryCs_d, entryTgt_d, entryStk_d} =
            {ctrl_q, entryCs_q, entryTgt_q, entryStk_q};
        {opA_d, opB_d, opC_d, tssSp_d, dseg_d} =
            {opA_q, opB_q, opC_q, tssSp_q, dseg_q};
        {cpl_d, sp_d, ip_d, cs_d, ss_d} = {cpl_q, sp_q, ip_q, cs_q, ss_q};
        {csLim_d, ssLim_d, longCode_d, ssLoaded_d} =
            {csLim_q, ssLim_q, longCode_q, ssLoaded_q};
        dsel_d = dsel_q;
        frame_d = frame_q;
        {fault_d, cmd_d, state_d} = {fault_q, cmd_q, state_q};
        awHeld_d = awHeld_q || s_axi_awvalid;
        wHeld_d = wHeld_q || s_axi_wvalid;
        awAddr_d = (!awHeld_q && s_axi_awvalid) ? s_axi_awaddr : awAddr_q;
        wData_d = (!wHeld_q && s_axi_wvalid) ? s_axi_wdata : wData_q;
        bValid_d = bValid_q && !s_axi_bready;
        bErr_d = bErr_q;
        rValid_d = rValid_q && !s_axi_rready;
        rData_d = rData_q;
        rErr_d = rErr_q;
        arAddr_d = arAddr_q;

        if (wrFire)
        begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bErr_d = 1'b0;
            case (awAddr_q)
                priv_xfer_pkg::OFF_CTRL:
                    ctrl_d = 2'(merge({30'h0, ctrl_q}, wData_q, s_axi_wstrb));
                priv_xfer_pkg::OFF_CMD:
                    if (state_q == IDLE_ST && wData_q[2:0] != 3'h0)
                    begin
                        cmd_d = wData_q[2:0];
                        fault_d = priv_xfer_pkg::FLT_NONE;
                        state_d = EXEC_ST;
                    end
                priv_xfer_pkg::OFF_ENTRY_CS: entryCs_d = wData_q[15:0];
                priv_xfer_pkg::OFF_ENTRY_TGT_LO: entryTgt_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_ENTRY_TGT_HI: entryTgt_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_ENTRY_STK_LO: entryStk_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_ENTRY_STK_HI: entryStk_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_OPA_LO: opA_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_OPA_HI: opA_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_OPB_LO: opB_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_OPB_HI: opB_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_OPC: opC_d = wData_q;
                priv_xfer_pkg::OFF_TSS_SP_LO: tssSp_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_TSS_SP_HI: tssSp_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_DSEG: dseg_d = wData_q;
                priv_xfer_pkg::OFF_CUR:
                begin
                    cpl_d = wData_q[1:0];
                    cs_d = wData_q[31:16];
                end
                priv_xfer_pkg::OFF_SP_LO: sp_d[31:0] = wData_q;
                priv_xfer_pkg::OFF_SP_HI: sp_d[63:32] = wData_q;
                priv_xfer_pkg::OFF_IP_LO: csLim_d = wData_q;
                priv_xfer_pkg::OFF_SEGS: ss_d = wData_q[15:0];
                priv_xfer_pkg::OFF_DATA_SEL:
                    for (int i = 0; i < 2; i++)
                        dsel_d[i] = wData_q[16*i +: 16];
                default:
                    if (awAddr_q >= priv_xfer_pkg::OFF_FRAME0 &&
                        awAddr_q < priv_xfer_pkg::OFF_FRAME0 + 8'h40)
                    begin
                        if (awAddr_q[2])
                            frame_d[slotOf(awAddr_q)][63:32] = wData_q;
                        else
                            frame_d[slotOf(awAddr_q)][31:0] = wData_q;
                    end
                    else
                        bErr_d = 1'b1;
            endcase
        end

        if (rdFire)
        begin
            case (s_axi_araddr)
                priv_xfer_pkg::OFF_CTRL: rd = {30'h0, ctrl_q};
                priv_xfer_pkg::OFF_STATUS:
                    rd = {24'h0, ssLoaded_q, longCode_q, fault_q, 1'b0,
                        state_q};
                priv_xfer_pkg::OFF_ENTRY_CS: rd = {16'h0, entryCs_q};
                priv_xfer_pkg::OFF_CUR: rd = {cs_q, 14'h0, cpl_q};
                priv_xfer_pkg::OFF_SP_LO: rd = sp_q[31:0];
                priv_xfer_pkg::OFF_SP_HI: rd = sp_q[63:32];
                priv_xfer_pkg::OFF_IP_LO: rd = ip_q[31:0];
                priv_xfer_pkg::OFF_IP_HI: rd = ip_q[63:32];
                priv_xfer_pkg::OFF_SEGS: rd = {16'h0, ss_q};
                priv_xfer_pkg::OFF_DATA_SEL: rd = {dsel_q[1], dsel_q[0]};
                priv_xfer_pkg::OFF_DSEG: rd = dseg_q;
                default:
                    if (s_axi_araddr >= priv_xfer_pkg::OFF_FRAME0 &&
                        s_axi_araddr < priv_xfer_pkg::OFF_FRAME0 + 8'h40)
                        rd = s_axi_araddr[2] ?
                            frame_q[slotOf(s_axi_araddr)][63:32] :
                            frame_q[slotOf(s_axi_araddr)][31:0];
                    else
                        hit = 1'b0;
            endcase
            rValid_d = 1'b1;
            rData_d = rd;
            rErr_d = !hit;
            arAddr_d = s_axi_araddr;
        end

        case (state_q)
            IDLE_ST: ;
            EXEC_ST:
            begin
                state_d = DONE_ST;
                case (cmd_q)
                    priv_xfer_pkg::CMD_FAR_CALL:
                    begin
                        // Target level from opC[1:0]; gate count in opC
                        // upper bits is not read by the far call (far return reads opC[31:16])
                        frame_d[0] = ip_q;
                        frame_d[1] = {48'h0, cs_q};
                        frame_d[2] = sp_q;
                        frame_d[3] = {48'h0, ss_q};
                        sp_d = tssSp_q - 4 * priv_xfer_pkg::SLOT_BYTES;
                        ss_d = {priv_xfer_pkg::NULL_SEL[15:2], opC_q[1:0]};
                        ssLoaded_d = 1'b0;
                        cpl_d = opC_q[1:0];
                        cs_d = opA_q[15:0];
                        ip_d = opB_q;
                    end
                    priv_xfer_pkg::CMD_NEAR_RET:
                        if (frame_q[0] > {32'h0, csLim_q})
                            fault_d = priv_xfer_pkg::FLT_GP;
                        else
                        begin
                            ip_d = frame_q[0];
                            sp_d = sp_q + priv_xfer_pkg::SLOT_BYTES;
                        end
                    priv_xfer_pkg::CMD_FAR_RET:
                        // Saved code selector requested level vs current
                        if (newLevel < cpl_q || newLevel < opA_q[1:0])
                            fault_d = priv_xfer_pkg::FLT_GP;
                        else
                        begin
                            ip_d = frame_q[0];
                            cs_d = frame_q[1][15:0];
                            spx = sp_q + 2 * priv_xfer_pkg::SLOT_BYTES;
                            if (newLevel > cpl_q)
                            begin
                                spx = spx + {48'h0, opC_q[31:16]};
                                if (frame_q[0][31:0] > opB_q[31:0])
                                    fault_d = priv_xfer_pkg::FLT_LIMIT;
                                // Popped NULL means no descriptor load
                                ss_d = frame_q[3][15:0];
                                ssLoaded_d = frame_q[3][15:2] != 14'h0;
                                spx = frame_q[2];
                                for (int i = 0; i < 4; i++)
                                    dsel_d[i] = scrubbed[i];
                                cpl_d = newLevel;
                            end
                            // Unchecked against the stack limit
                            sp_d = spx + {48'h0, opC_q[31:16]};
                        end
                    priv_xfer_pkg::CMD_INT_RET:
                        if (frame_q[3][15:2] == 14'h0 &&
                            !(ctrl_q[priv_xfer_pkg::CTRL_M64] &&
                            newLevel != priv_xfer_pkg::LEVEL_USER))
                            fault_d = priv_xfer_pkg::FLT_GP;
                        else
                        begin
                            ss_d = frame_q[3][15:0];
                            ssLoaded_d = frame_q[3][15:2] != 14'h0;
                            ip_d = frame_q[0];
                            cs_d = frame_q[1][15:0];
                            cpl_d = newLevel;
                        end
                    priv_xfer_pkg::CMD_ENTRY:
                    begin
                        // Accepted from every level
                        cs_d = fastTgt.codeSel;
                        ss_d = fastTgt.stackSel;
                        ip_d = fastTgt.ip;
                        sp_d = fastTgt.sp;
                        longCode_d = fastTgt.longCode;
                        csLim_d = fastTgt.csLimit;
                        ssLim_d = fastTgt.ssLimit;
                        cpl_d = priv_xfer_pkg::LEVEL_TOP;
                    end
                    default:
                        if (cpl_q != priv_xfer_pkg::LEVEL_TOP)
                            fault_d = priv_xfer_pkg::FLT_GP;
                        else
                        begin
                            cs_d = fastTgt.codeSel;
                            ss_d = fastTgt.stackSel;
                            ip_d = fastTgt.ip;
                            sp_d = fastTgt.sp;
                            longCode_d = fastTgt.longCode;
                            cpl_d = priv_xfer_pkg::LEVEL_USER;
                        end
                endcase
            end
            DONE_ST: state_d = IDLE_ST;
            default: state_d = IDLE_ST;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {ctrl_q, entryCs_q, entryTgt_q, entryStk_q} <= '0;
            {opA_q, opB_q, opC_q, tssSp_q, dseg_q} <= '0;
            {cpl_q, sp_q, ip_q, cs_q, ss_q} <= '0;
            {csLim_q, ssLim_q, longCode_q, ssLoaded_q} <= '0;
            dsel_q <= '{default: 16'h0};
            frame_q <= '{default: 64'h0};
            {fault_q, cmd_q} <= '0;
            state_q <= IDLE_ST;
            {awHeld_q, wHeld_q, bValid_q, bErr_q} <= '0;
            {rValid_q, rErr_q, awAddr_q, arAddr_q} <= '0;
            {wData_q, rData_q} <= '0;
        end
        else
        begin
            {ctrl_q, entryCs_q, entryTgt_q, entryStk_q} <=
                {ctrl_d, entryCs_d, entryTgt_d, entryStk_d};
            {opA_q, opB_q, opC_q, tssSp_q, dseg_q} <=
                {opA_d, opB_d, opC_d, tssSp_d, dseg_d};
            {cpl_q, sp_q, ip_q, cs_q, ss_q} <= {cpl_d, sp_d, ip_d, cs_d, ss_d};
            {csLim_q, ssLim_q, longCode_q, ssLoaded_q} <=
                {csLim_d, ssLim_d, longCode_d, ssLoaded_d};
            dsel_q <= dsel_d;
            frame_q <= frame_d;
            {fault_q, cmd_q} <= {fault_d, cmd_d};
            state_q <= state_d;
            {awHeld_q, wHeld_q, bValid_q, bErr_q} <=
                {awHeld_d, wHeld_d, bValid_d, bErr_d};
            {rValid_q, rErr_q, awAddr_q, arAddr_q} <=
                {rValid_d, rErr_d, awAddr_d, arAddr_d};
            {wData_q, rData_q} <= {wData_d, rData_d};
        end
    end
endmodule // privilege_transfer_unit

/* tb/priv_xfer_assertions.sv */
// Register bus handshake checks for the privilege transfer unit
`timescale 1ns/1ps
module priv_xfer_assertions
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped early");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        $stable(s_axi_bresp)) else $error("write response changed");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        $stable(s_axi_rdata)) else $error("read data changed");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during write answer");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("data taken during write answer");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during read answer");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
endmodule // priv_xfer_assertions

bind privilege_transfer_unit priv_xfer_assertions priv_xfer_assertions_inst
(
    .clk(clk), .arst_n(arst_n), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata)
);

/* tb/privilege_transfer_unit_test.sv */
// Directed bench for the privilege transfer unit
`timescale 1ns/1ps
module privilege_transfer_unit_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    // Answer channels always ready
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b1;
    logic arValid = 1'b0, rReady = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0, rData, rd32, st;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, resp;
    int errCount = 0, nTests = 0;
    privilege_transfer_unit privilege_transfer_unit_inst
    (
        .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady)
    );
    initial forever #25 clk = ~clk;
    task automatic finishTest();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        nTests++;
        if (g !== e)
        begin
            errCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes judged at the falling edge, acted on after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1;
        while (!tb)
        begin
            @(negedge clk);
            ta = awValid && awReady; tw = wValid && wReady;
            tb = bValid; resp = bResp;
            @(posedge clk);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ta, tr;
        tr = 1'b0;
        arAddr <= a; arValid <= 1'b1;
        while (!tr)
        begin
            @(negedge clk);
            ta = arValid && arReady; tr = rValid; d = rData; resp = rResp;
            @(posedge clk);
            if (ta) arValid <= 1'b0;
        end
    endtask
    task automatic run(input logic [2:0] c);
        wr(8'h04, 32'(c));
        rd(8'h08, st);
        while (st[2:0] !== 3'h1) rd(8'h08, st);
    endtask
    task automatic xfer(input logic [2:0] c, input logic [15:0] cs, ss,
        input logic [31:0] ipLo, ipHi);
        run(c);
        chk("fault", 32'h0, 32'(st[5:4]));
        rd(8'h40, rd32); chk("cs", 32'(cs), 32'(rd32[31:16]));
        rd(8'h54, rd32); chk("ss", 32'(ss), 32'(rd32[15:0]));
        rd(8'h4c, rd32); chk("ip lo", ipLo, rd32);
        rd(8'h50, rd32); chk("ip hi", ipHi, rd32);
    endtask
    task automatic busTest();
        wr(8'hfc, 32'h1); chk("wr resp", 32'h2, 32'(resp));
        rd(8'hfc, rd32); chk("rd resp", 32'h2, 32'(resp));
        $display("bus test done");
    endtask
    task automatic entryTest();
        wr(8'h0c, 32'h10);
        wr(8'h10, 32'h12345678); wr(8'h14, 32'hab);
        wr(8'h18, 32'h9abcdef0); wr(8'h1c, 32'hcd); wr(8'h00, 32'h3);
        for (int l = 3; l >= 0; l--)
        begin
            wr(8'h40, 32'(l));
            xfer(3'h5, 16'h10, 16'h18, 32'h12345678, 32'hab);
        end
        rd(8'h48, rd32); chk("sp hi", 32'hcd, rd32);
        wr(8'h00, 32'h0);
        xfer(3'h5, 16'h10, 16'h18, 32'h12345678, 32'h0);
        rd(8'h44, rd32); chk("sp lo", 32'h9abcdef0, rd32);
        $display("entry test done");
    endtask
    task automatic exitTest();
        wr(8'h00, 32'h3); wr(8'h20, 32'h401000); wr(8'h24, 32'h1);
        wr(8'h28, 32'h502000); wr(8'h2c, 32'h2); wr(8'h40, 32'h0);
        xfer(3'h6, 16'h20, 16'h28, 32'h401000, 32'h0);
        chk("long", 32'h0, 32'(st[6]));
        rd(8'h44, rd32); chk("sp lo", 32'h502000, rd32);
        wr(8'h40, 32'h0);
        xfer(3'h7, 16'h30, 16'h38, 32'h401000, 32'h1);
        chk("long", 32'h1, 32'(st[6]));
        rd(8'h48, rd32); chk("sp hi", 32'h2, rd32);
        for (int l = 1; l < 4; l++)
        begin
            wr(8'h40, 32'(l));
            run(3'h6);
            chk("exit fault", 32'h1, 32'(st[5:4]));
        end
        $display("exit test done");
    endtask
    task automatic callTest();
        logic [31:0] fr [4] = '{32'h401000, 32'h23, 32'h502000, 32'h38};
        wr(8'h40, 32'h230003); wr(8'h34, 32'h8000); wr(8'h20, 32'h8);
        wr(8'h30, 32'h1000fc); wr(8'h58, 32'h300028); wr(8'h3c, 32'h400);
        xfer(3'h1, 16'h8, 16'h0, 32'h502000, 32'h2);
        chk("ss loaded", 32'h0, 32'(st[7]));
        rd(8'h44, rd32); chk("sp lo", 32'h7fe0, rd32);
        for (int i = 0; i < 4; i++)
        begin
            rd(8'(8'h60 + 8 * i), rd32); chk("frame", fr[i], rd32);
        end
        xfer(3'h2, 16'h23, 16'h38, 32'h401000, 32'h1);
        chk("ss loaded", 32'h1, 32'(st[7]));
        rd(8'h44, rd32); chk("sp lo", 32'h502010, rd32);
        rd(8'h58, rd32); chk("data sel", 32'h300000, rd32);
        run(3'h3); chk("near fault", 32'h1, 32'(st[5:4]));
        wr(8'h64, 32'h0); run(3'h3);
        rd(8'h44, rd32); chk("near sp", 32'h502018, rd32);
        wr(8'h68, 32'h20); run(3'h2);
        chk("inward", 32'h1, 32'(st[5:4]));
        wr(8'h78, 32'h0); run(3'h4);
        chk("null ss", 32'h0, 32'({st[7], st[5:4]}));
        $display("call test done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        busTest();
        entryTest();
        exitTest();
        callTest();
        finishTest();
    end
    // Roughly six times the expected run
    initial
    begin
        #100000;
        errCount++;
        finishTest();
    end
endmodule // privilege_transfer_unit_test
